// ===== test/hpl_host_model.sv
/* host processor model: one byte per strobe access.
   assumes the bench resolves the data wire from the port's output enable alone. */
`timescale 1ns/100ps
`default_nettype none
module hpl_host_model (
	input wire logic clk_sys,
	output logic chip_sel_n,
	output logic read_n,
	output logic write_n,
	output logic [4:0] location_select,
	output logic [7:0] data_drv,
	input wire logic [7:0] data_wire,
	input wire logic data_oe
);
	// =====
	// idle: strobes high, lines scrambled once hold runs out
	initial begin
		chip_sel_n = 1'b1;
		read_n = 1'b1;
		write_n = 1'b1;
		location_select = 5'h00;
		data_drv = 8'hFF;
	end
	task automatic acc(input logic w, input logic [4:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_sys);
		location_select <= a;
		data_drv <= w ? d : ~data_drv;
		chip_sel_n <= 1'b0;
		read_n <= w;
		write_n <= !w;
		repeat (6) @(posedge clk_sys);
		// undriven bus reads high through pull-ups
		q = data_oe ? data_wire : 8'hFF;
		chip_sel_n <= 1'b1;
		read_n <= 1'b1;
		write_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		location_select <= ~a;
		data_drv <= ~data_drv;
		repeat (3) @(posedge clk_sys);
	endtask
endmodule // hpl_host_model
`default_nettype wire

// ===== test/hpl_host_monitor.sv
/* checker on the host port pins.
   assumes LOCK_CYC equals the design's own value. */
`timescale 1ns/100ps
`default_nettype none
module hpl_host_monitor #(
	parameter int unsigned LOCK_CYC = 8
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic chip_sel_n,
	input wire logic read_n,
	input wire logic write_n,
	input wire logic host_data_bus_oe,
	input wire logic power_loss_input,
	input wire logic lockout
);
	// =====
	// ages: cycles of power loss, cycles since a read
	logic [11:0] low_q;
	logic [3:0] rd_q;
	wire logic oe = host_data_bus_oe;
	wire logic pl = power_loss_input;
	wire logic rd_pair = !chip_sel_n && !read_n;
	// limitation: low_q wraps after 4095 cycles of power loss
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			low_q <= 12'h000;
			rd_q <= 4'hF;
		end else begin
			low_q <= pl ? 12'h000 : low_q + 12'h001;
			rd_q <= rd_pair ? 4'h0 : rd_q + {3'h0, rd_q != 4'hF};
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// =====
	// properties
	property p_oe_cause; $rose(oe) |-> $past(rd_pair, 2); endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("oe w/o read");
	property p_oe_recent; oe |-> rd_q < 4'h4; endproperty
	a_oe_recent: assert property (p_oe_recent) else $error("stale oe");
	property p_rd_end; $rose(read_n) |-> ##[1:6] !oe; endproperty
	a_rd_end: assert property (p_rd_end) else $error("oe held");
	property p_wr_quiet; !chip_sel_n && !write_n |-> !oe; endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("oe in write");
	property p_pl_float; (!pl) [*5] |-> !oe; endproperty
	a_pl_float: assert property (p_pl_float) else $error("oe at loss");
	property p_lock_min; $rose(lockout) |-> low_q >= LOCK_CYC; endproperty
	a_lock_min: assert property (p_lock_min) else $error("early lock");
	property p_lock_clr; $rose(pl) |-> ##[1:4] !lockout; endproperty
	a_lock_clr: assert property (p_lock_clr) else $error("lock held");
	property p_lock_quiet; lockout |-> !oe; endproperty
	a_lock_quiet: assert property (p_lock_quiet) else $error("oe locked");
endmodule // hpl_host_monitor
bind hpl_host_port hpl_host_monitor #(.LOCK_CYC(LOCK_CYC)) hpl_host_monitor_inst (
	.clk_sys, .reset_n, .chip_sel_n, .read_n, .write_n,
	.host_data_bus_oe, .power_loss_input, .lockout);
`default_nettype wire

// ===== test/testbench.sv
/* bench: register rows in a loop, then events, pins and power loss.
   assumes the checker is bound in from its own file. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk_sys, reset_n, chip_sel_n, read_n, write_n, crystal_input;
	logic power_loss_input, power_good, timer_clk_in, timer0_out;
	logic timer0_gate_n, timer1_gate_n, timer1_out, lockout;
	logic host_data_bus_oe, crystal_output, timer_count_en0;
	logic timer_count_en1, host_irq_out, host_irq_out_oe;
	logic multi_use_output, multi_use_output_oe;
	logic second_timer_output, second_timer_output_oe;
	logic [4:0] location_select;
	logic [3:0] irq_events;
	logic [7:0] host_data_bus_i, host_data_bus_o, host_drv, lockout_delay;
	logic [7:0] q, c, pins;
	logic [2:0] div_q = 3'h0;
	int fails = 0;
	int n_compared = 0;
	// rows: location, written, read back
	logic [7:0] tbl [6][3] = '{'{8'h04, 8'h01, 8'h01},
		'{8'h01, 8'h0D, 8'h0D}, '{8'h02, 8'h04, 8'h04},
		'{8'h03, 8'h01, 8'h01}, '{8'h05, 8'h80, 8'h80},
		'{8'h1F, 8'h5A, 8'h00}};
	hpl_host_port #(.LOCK_CYC(8)) hpl_host_port_inst (.clk_sys, .reset_n,
		.chip_sel_n, .read_n, .write_n, .location_select, .host_data_bus_i,
		.host_data_bus_o, .host_data_bus_oe, .power_loss_input, .power_good,
		.irq_events, .lockout_delay, .crystal_input, .crystal_output,
		.timer_clk_in, .timer0_gate_n, .timer1_gate_n, .timer0_out,
		.timer1_out, .timer_count_en0, .timer_count_en1, .host_irq_out,
		.host_irq_out_oe, .multi_use_output, .multi_use_output_oe,
		.second_timer_output, .second_timer_output_oe, .lockout);
	hpl_host_model hpl_host_model_inst (.clk_sys, .chip_sel_n, .read_n,
		.write_n, .location_select, .data_drv(host_drv),
		.data_wire(host_data_bus_i), .data_oe(host_data_bus_oe));
	assign host_data_bus_i = host_data_bus_oe ? host_data_bus_o : host_drv;
	// released open drain reads high through the pull-up
	assign pins = {host_irq_out_oe, host_irq_out,
		multi_use_output_oe ? multi_use_output : 1'b1, multi_use_output_oe,
		second_timer_output, timer_count_en0, timer_count_en1, lockout};
	assign crystal_input = div_q[2];
	// =====
	// clock and tasks
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) div_q <= div_q + 3'h1;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		hpl_host_model_inst.acc(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		hpl_host_model_inst.acc(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic pulse(input logic [3:0] v, input logic [7:0] e);
		@(posedge clk_sys);
		irq_events <= v;
		@(posedge clk_sys);
		irq_events <= 4'h0;
		repeat (5) @(posedge clk_sys);
		chk(pins, e);
	endtask
	task automatic conclude;
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys);
		fails++;
		conclude;
	end
	// =====
	// main sequence
	initial begin
		reset_n = 1'b0;
		power_loss_input = 1'b1;
		power_good = 1'b1;
		irq_events = 4'h0;
		lockout_delay = 8'h00;
		timer_clk_in = 1'b0;
		timer0_gate_n = 1'b1;
		timer1_gate_n = 1'b1;
		timer0_out = 1'b0;
		timer1_out = 1'b0;
		repeat (6) @(posedge clk_sys);
		chk(pins, 8'h20);
		reset_n <= 1'b1;
		repeat (20) @(posedge clk_sys);
		chk({7'h00, crystal_output}, 8'h00);
		$display("done: reset");
		for (int i = 0; i < 6; i++) begin
			wr(tbl[i][0][4:0], tbl[i][1]);
			rd(tbl[i][0][4:0], tbl[i][2]);
		end
		c = {7'h00, crystal_output};
		repeat (4) @(posedge clk_sys);
		chk(c ^ {7'h00, crystal_output}, 8'h01);
		power_good <= 1'b0;
		repeat (4) @(posedge clk_sys);
		c = {7'h00, crystal_output};
		repeat (4) @(posedge clk_sys);
		chk(c | {7'h00, crystal_output}, 8'h00);
		power_good <= 1'b1;
		$display("done: registers");
		pulse(4'h2, 8'hB8);
		pulse(4'h1, 8'hF8);
		pulse(4'h4, 8'hD8);
		rd(5'h00, 8'h07);
		pulse(4'h0, 8'hB8);
		$display("done: events");
		wr(5'h03, 8'h20);
		chk(pins, 8'hE8);
		wr(5'h03, 8'h58);
		timer0_out <= 1'b1;
		timer1_out <= 1'b1;
		timer0_gate_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		chk(pins, 8'hFC);
		chk({7'h00, second_timer_output_oe}, 8'h01);
		timer0_out <= 1'b0;
		timer1_out <= 1'b0;
		timer0_gate_n <= 1'b1;
		timer1_gate_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		chk(pins, 8'hD2);
		// open drain everywhere, oscillator on the multi-use pin
		wr(5'h03, 8'hA6);
		c = pins;
		repeat (4) @(posedge clk_sys);
		chk(c ^ pins, 8'h30);
		c = {6'h00, host_irq_out_oe, second_timer_output_oe};
		chk(c, 8'h00);
		wr(5'h03, 8'h58);
		wr(5'h04, 8'h05);
		c = 8'h00;
		for (int i = 0; i < 22; i++) begin
			@(posedge clk_sys);
			if (i < 16)
				timer_clk_in <= ~timer_clk_in;
			c = c + {7'h00, timer_count_en1};
		end
		chk(c, 8'h08);
		wr(5'h04, 8'h01);
		$display("done: pins");
		// loss seen before the write; lockout lands mid-write
		power_loss_input <= 1'b0;
		repeat (2) @(posedge clk_sys);
		wr(5'h02, 8'h01);
		repeat (3) @(posedge clk_sys);
		chk(pins, 8'h93);
		wr(5'h02, 8'hFF);
		rd(5'h02, 8'hFF);
		power_loss_input <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk(pins, 8'h92);
		rd(5'h02, 8'h01);
		rd(5'h00, 8'h08);
		// programmed 2 us delay replaces the fixed window
		lockout_delay <= 8'h02;
		power_loss_input <= 1'b0;
		repeat (20) @(posedge clk_sys);
		chk({7'h00, lockout}, 8'h00);
		repeat (6) @(posedge clk_sys);
		chk({7'h00, lockout}, 8'h01);
		power_loss_input <= 1'b1;
		lockout_delay <= 8'h00;
		repeat (5) @(posedge clk_sys);
		wr(5'h05, 8'h00);
		rd(5'h00, 8'h08);
		power_loss_input <= 1'b0;
		repeat (20) @(posedge clk_sys);
		chk({7'h00, lockout}, 8'h00);
		rd(5'h00, 8'hFF);
		power_loss_input <= 1'b1;
		repeat (5) @(posedge clk_sys);
		rd(5'h00, 8'h00);
		$display("done: power loss");
		conclude;
	end
endmodule // testbench
`default_nettype wire

// ===== verilog/hpl_host_port.sv
/*
 * asynchronous host port with power-loss lockout, interrupt routing and
 * programmable output pins.
 * assumes host strobes are asynchronous, each over 3 system clocks wide.
 */
`timescale 1ns/100ps
`default_nettype none
module hpl_host_port
	import hpl_pkg::*;
#(
	parameter int unsigned LOCK_CYC = LOCKOUT_CYC
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic chip_sel_n,
	input wire logic read_n,
	input wire logic write_n,
	input wire logic [ADDR_W-1:0] location_select,
	input wire logic [DATA_W-1:0] host_data_bus_i,
	output logic [DATA_W-1:0] host_data_bus_o,
	output logic host_data_bus_oe,
	input wire logic power_loss_input,
	input wire logic power_good,
	input wire logic [3:0] irq_events,
	input wire logic [7:0] lockout_delay,
	input wire logic crystal_input,
	output logic crystal_output,
	input wire logic timer_clk_in,
	input wire logic timer0_gate_n,
	input wire logic timer1_gate_n,
	input wire logic timer0_out,
	input wire logic timer1_out,
	output logic timer_count_en0,
	output logic timer_count_en1,
	output logic host_irq_out,
	output logic host_irq_out_oe,
	output logic multi_use_output,
	output logic multi_use_output_oe,
	output logic second_timer_output,
	output logic second_timer_output_oe,
	output logic lockout
);
	typedef struct packed {
		hpl_acc_t acc;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] rdat;
		logic drive;
		logic [NUM_IRQ-1:0] stat;
		logic [7:0] mask;
		logic [7:0] route;
		logic [7:0] cfg;
		logic [7:0] rtmode;
		logic [7:0] pfctrl;
		logic [LOCK_CNT_W-1:0] lcnt;
		logic lock;
		logic osc;
		logic tck_prev;
		logic en0;
		logic en1;
	} hpl_state_t;
	hpl_state_t s_q, s_d;

	logic rst_m, rst_n;
	logic [9:0] sy1, sy2;
	logic cs_n, rd_n, wr_n, pl, tck, g0n, g1n, xi, t0o, t1o;
	logic sel_rd, sel_wr, irq_a, irq_b, mfo_act;
	logic [NUM_IRQ-1:0] pend;

	// ===========================================================
	// reset release and pin synchronisers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_m <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_n <= rst_m;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			// idle levels: strobes, power and gates high, clocks and timer outputs low
			sy1 <= 10'h3D8;
			sy2 <= 10'h3D8;
		end else begin
			sy1 <= {chip_sel_n, read_n, write_n, power_loss_input,
				timer_clk_in, timer0_gate_n, timer1_gate_n,
				crystal_input, timer0_out, timer1_out};
			sy2 <= sy1;
		end
	end
	assign {cs_n, rd_n, wr_n, pl, tck, g0n, g1n, xi, t0o, t1o} = sy2;

	// address and write data held steady by the host around strobes
	assign sel_rd = ~cs_n & ~rd_n;
	assign sel_wr = ~cs_n & ~wr_n;
	assign pend = s_q.stat & s_q.mask[NUM_IRQ-1:0];
	// route bit set sends the source to the multi-use pin
	assign irq_a = |(pend & ~s_q.route[NUM_IRQ-1:0]);
	assign irq_b = |(pend & s_q.route[NUM_IRQ-1:0]);

	// ===========================================================
	// next state
	always_comb begin
		s_d = s_q;
		s_d.stat = s_q.stat | irq_events;
		s_d.tck_prev = tck;
		s_d.en0 = ~g0n & (~s_q.rtmode[TMR_EXT_BIT] | (tck & ~s_q.tck_prev));
		s_d.en1 = ~g1n & (~s_q.rtmode[TMR_EXT_BIT] | (tck & ~s_q.tck_prev));
		// oscillator stopped until crystal bits valid and power present
		s_d.osc = xi & power_good & (|s_q.rtmode[XTAL_SEL_LSB +: 2]);

		// lockout timing; zero programmed delay uses the fixed window
		if (pl || !s_q.pfctrl[PF_ENABLE_BIT]) begin
			s_d.lcnt = '0;
			s_d.lock = 1'b0;
		end else if (!s_q.lock) begin
			s_d.lcnt = LOCK_CNT_W'(s_q.lcnt + 1'b1);
			if (lockout_delay != 8'h00) begin
				if (s_q.lcnt >= {4'h0, lockout_delay}
					* LOCK_CNT_W'(CLK_HZ / 1000000))
					s_d.lock = 1'b1;
			end else if (s_q.lcnt >= LOCK_CNT_W'(LOCK_CYC - 1)) begin
				s_d.lock = 1'b1;
			end
		end
		unique case (s_q.acc)
			HPL_IDLE: begin
				s_d.drive = 1'b0;
				// new accesses refused while locked
				if (!s_q.lock && sel_rd) begin
					s_d.acc = HPL_READ;
					s_d.addr = location_select;
				end else if (!s_q.lock && sel_wr) begin
					s_d.acc = HPL_WRITE;
					s_d.addr = location_select;
				end
			end
			HPL_READ: begin
				// read finishes even if lockout arrives meanwhile
				s_d.drive = sel_rd & pl;
				unique case (s_q.addr)
					ADDR_STATUS: s_d.rdat = {4'h0, s_q.stat};
					ADDR_MASK: s_d.rdat = s_q.mask;
					ADDR_ROUTE: s_d.rdat = s_q.route;
					ADDR_OUTCFG: s_d.rdat = s_q.cfg;
					ADDR_RTMODE: s_d.rdat = s_q.rtmode;
					ADDR_PFCTRL: s_d.rdat = s_q.pfctrl;
					default: s_d.rdat = 8'h00;
				endcase
				if (!sel_rd) begin
					s_d.acc = HPL_IDLE;
					// reading status clears it; new events still win
					if (s_q.addr == ADDR_STATUS)
						s_d.stat = irq_events;
				end
			end
			HPL_WRITE: begin
				s_d.drive = 1'b0;
				if (!sel_wr) begin
					s_d.acc = HPL_IDLE;
					unique case (s_q.addr)
						ADDR_MASK: s_d.mask = host_data_bus_i;
						ADDR_ROUTE: s_d.route = host_data_bus_i;
						ADDR_OUTCFG: s_d.cfg = host_data_bus_i;
						ADDR_RTMODE: s_d.rtmode = host_data_bus_i;
						ADDR_PFCTRL: s_d.pfctrl = host_data_bus_i;
						default: ;
					endcase
				end
			end
			default: s_d.acc = HPL_IDLE;
		endcase
		// set last so a status read clear cannot drop it
		if (!pl && s_q.pfctrl[PF_ENABLE_BIT])
			s_d.stat[IRQ_POWER_LOSS_INPUT] = 1'b1;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.acc <= HPL_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ===========================================================
	// outputs
	always_comb begin
		unique case (s_q.cfg[CFG_MFO_SEL +: 2])
			MFO_OSC: mfo_act = s_q.osc;
			MFO_TMR0: mfo_act = t0o;
			default: mfo_act = irq_b;
		endcase
	end

	hpl_pin_drv u_irq (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.active(irq_a),
		.active_high(s_q.cfg[CFG_IRQ_POL]),
		.open_drain(s_q.cfg[CFG_IRQ_OD]),
		.pin_o(host_irq_out),
		.pin_oe(host_irq_out_oe)
	);
	hpl_pin_drv u_mfo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.active(mfo_act),
		.active_high(s_q.cfg[CFG_MFO_POL]),
		.open_drain(s_q.cfg[CFG_MFO_OD]),
		.pin_o(multi_use_output),
		.pin_oe(multi_use_output_oe)
	);
	hpl_pin_drv u_t1 (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.active(t1o),
		.active_high(s_q.cfg[CFG_T1_POL]),
		.open_drain(s_q.cfg[CFG_T1_OD]),
		.pin_o(second_timer_output),
		.pin_oe(second_timer_output_oe)
	);

	assign host_data_bus_o = s_q.rdat;
	assign host_data_bus_oe = s_q.drive;
	assign crystal_output = s_q.osc;
	assign timer_count_en0 = s_q.en0;
	assign timer_count_en1 = s_q.en1;
	assign lockout = s_q.lock;
endmodule // hpl_host_port
`default_nettype wire

// ===== verilog/hpl_pin_drv.sv
/*
 * one programmable output pin: polarity and open-drain or push-pull.
 * assumes a pull-up outside for open-drain use.
 */
`timescale 1ns/100ps
`default_nettype none
module hpl_pin_drv (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic active,
	input wire logic active_high,
	input wire logic open_drain,
	output logic pin_o,
	output logic pin_oe
);
	typedef struct packed {
		logic o;
		logic oe;
	} hpl_pin_t;
	hpl_pin_t s_q, s_d;

	// ===========================================================
	// level and enable
	always_comb begin
		s_d.o = active ~^ active_high;
		// open drain only pulls low
		s_d.oe = open_drain ? ~s_d.o : 1'b1;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pin_o = s_q.o;
	assign pin_oe = s_q.oe;
endmodule // hpl_pin_drv
`default_nettype wire

// ===== verilog/hpl_pkg.sv
/*
 * constants for the host port with power lockout.
 * assumes one 10 MHz system clock; strobe, power-loss, timer and crystal pins are sampled into it.
 */
// Summary of operation
// - four interrupt classes, periodic, alarm, timer, power fail, maskable, status readable
// - dedicated irq output plus second irq on multi-use pin, any source routable
// - multi-use pin carries second irq, buffered oscillator or timer 0 output
// - multi-use pin polarity and open-drain or push-pull drive programmable
// - irq output asserts on enabled event not routed to the multi-use pin; polarity and drive programmable
// - chip select, read and write strobes are active low; access needs both
// - read starts with select and read low, ends when either goes high
// - write starts with select and write low, captures data when either rises
// - in lockout strobes are ignored but an access in progress completes
// - five location select lines decode a register, ignored in lockout
// - data lines driven only in reads, floated during power loss even mid-read
// - power loss low enters lockout after 30 to 63 us unless delay programmed
// - oscillator runs only with power and valid crystal select bits written
// - both timers count the shared external timer clock when selected, to 5 MHz
// - two active-low gate inputs enable timer 0 and timer 1
// - second timer output pin has programmable polarity and drive
// - control bit 7 enables the lockout and power-fail interrupt; zero disables them, data lines still float during power loss
package hpl_pkg;

	// ===========================================================
	// timing
	localparam int unsigned CLK_HZ = 10000000;
	localparam int unsigned LOCKOUT_MIN_US = 30;
	localparam int unsigned LOCKOUT_MAX_US = 63;
	// least time; clocks per us rounds down
	localparam int unsigned LOCKOUT_CYC =
		(LOCKOUT_MIN_US * (CLK_HZ / 1000000));
	localparam int unsigned LOCK_CNT_W = 12;

	// ===========================================================
	// register map and fields
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 8;
	localparam logic [4:0] ADDR_STATUS = 5'h00;
	localparam logic [4:0] ADDR_MASK = 5'h01;
	localparam logic [4:0] ADDR_ROUTE = 5'h02;
	localparam logic [4:0] ADDR_OUTCFG = 5'h03;
	localparam logic [4:0] ADDR_RTMODE = 5'h04;
	localparam logic [4:0] ADDR_PFCTRL = 5'h05;
	localparam int unsigned PF_ENABLE_BIT = 7;
	localparam int unsigned XTAL_SEL_LSB = 0;
	localparam int unsigned TMR_EXT_BIT = 2;
	localparam int unsigned NUM_IRQ = 4;
	localparam int unsigned IRQ_PERIODIC = 0;
	localparam int unsigned IRQ_ALARM = 1;
	localparam int unsigned IRQ_TIMER = 2;
	localparam int unsigned IRQ_POWER_LOSS_INPUT = 3;
	// out config: [0] irq pol, [1] irq od, [3:2] mfo sel, [4] mfo pol,
	// [5] mfo od, [6] t1 pol, [7] t1 od
	localparam int unsigned CFG_IRQ_POL = 0;
	localparam int unsigned CFG_IRQ_OD = 1;
	localparam int unsigned CFG_MFO_SEL = 2;
	localparam int unsigned CFG_MFO_POL = 4;
	localparam int unsigned CFG_MFO_OD = 5;
	localparam int unsigned CFG_T1_POL = 6;
	localparam int unsigned CFG_T1_OD = 7;
	localparam logic [1:0] MFO_IRQ = 2'h0;
	localparam logic [1:0] MFO_OSC = 2'h1;
	localparam logic [1:0] MFO_TMR0 = 2'h2;
	localparam logic [7:0] REG_RESET = 8'h00;

	typedef enum logic [1:0] {HPL_IDLE, HPL_READ, HPL_WRITE} hpl_acc_t;

endpackage : hpl_pkg
